// [scs_slave.sv]
// Slow-control packet slave: link controller, main controller, register RAM
//
// Operation
// [R1] Only addressed master-to-slave and reply transfers
// [R2] One-byte addresses: slots 0-39, master 192
// [R3] Packets are sixteen bytes; padding ignored
// [R4] Receive time-out of 2 ms drops partial packets
// [R5] Slave transmits only to answer its packet
// [R6] Reply echoes packet with addresses swapped
// [R7] Byte zero is the 0x40 start delimiter
// [R8] Layout: dest, source, instruction, payload, checksum
// [R9] CRC-8 x^8+x^2+x+1 over bytes 0-14
// [R10] Bad CRC: no reply, bump error counter
// [R11] Master retransmits after its own time-out
// [R12] Codes 00, 03, 06 write settings
// [R13] Codes 01, 02, 04, 07 read registers
// [R14] Code 05 answers with plain echo
// [R15] Main controller idles until clocks lock
// [R16] Initialise all registers, then run
// [R17] Run left for counts or commands only; the code also leaves it for CRC errors
// [R18] Link rests receiving with receiver enabled
// [R19] Notify main, await ready, transmit, receive
// [R20] Only main controller touches register RAM
// [R21] Read-only registers ignore master writes
// [R22] Converter values 12 bits, top nibble zero
// [R23] Foreign destination silently discarded
// [R24] CRC zero start, msb first; resync
`timescale 1ns/1ps
module scs_slave #(
    parameter int TIMEOUT_CYC = scs_pkg::TIMEOUT_CYC
) (
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Board pins
    input  wire logic                 clk_locked,
    input  wire logic [7:0]           slot_addr,
    // Bytes from the line receiver
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_data,
    // Bytes to the line driver
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    output logic [7:0]                tx_data,
    output logic                      rx_en,
    output logic                      drive_en,
    // Completed counts from the counter datapath
    input  wire logic                 counts_valid,
    input  wire scs_pkg::scs_counts_t counts,
    // Settings bytes to the converter, enable and prescale units
    output logic                      cfg_valid,
    output scs_pkg::scs_cfg_t         cfg,
    output logic                      running
);
    typedef enum logic [7:0] {
        M_IDLE = 8'h01, M_INIT = 8'h02, M_RUN = 8'h04, M_STORE = 8'h08,
        M_ERR = 8'h10, M_CMD = 8'h20, M_CONFIG = 8'h40, M_DONE = 8'h80
    } scs_main_t;
    typedef enum logic [2:0] {L_RX = 3'b001, L_WAIT = 3'b010, L_TX = 3'b100} scs_link_t;

    // Bytes moved by each instruction
    function automatic logic [3:0] cmd_len(input logic [7:0] ins);
        case (ins)
            scs_pkg::INS_SET_DAC, scs_pkg::INS_RD_DAC: cmd_len = scs_pkg::N_DAC;
            scs_pkg::INS_RD_RATES: cmd_len = scs_pkg::N_RATES_RD;
            scs_pkg::INS_SET_EN, scs_pkg::INS_RD_EN: cmd_len = scs_pkg::N_ENABLE;
            scs_pkg::INS_SET_MODE: cmd_len = scs_pkg::N_PRESCALE;
            scs_pkg::INS_RD_MODE: cmd_len = scs_pkg::N_CNTMODE;
            default: cmd_len = 4'h0;
        endcase
    endfunction

    // Register address of payload byte idx for an instruction
    function automatic logic [4:0] ram_addr(input logic [7:0] ins, input logic [3:0] idx);
        case (ins)
            scs_pkg::INS_SET_DAC, scs_pkg::INS_RD_DAC: ram_addr = scs_pkg::RA_DAC + 5'(idx);
            scs_pkg::INS_RD_RATES:
                ram_addr = (idx < scs_pkg::N_RATES) ? scs_pkg::RA_RATES + 5'(idx)
                                                    : scs_pkg::RA_OVF;
            scs_pkg::INS_SET_EN, scs_pkg::INS_RD_EN: ram_addr = scs_pkg::RA_ENABLE + 5'(idx);
            scs_pkg::INS_SET_MODE: ram_addr = scs_pkg::RA_PRESCALE;
            scs_pkg::INS_RD_MODE:
                ram_addr = (idx == 4'h0) ? scs_pkg::RA_PRESCALE : scs_pkg::RA_OVF;
            default: ram_addr = scs_pkg::RA_SPARE;
        endcase
    endfunction

    function automatic logic is_write(input logic [7:0] ins);
        return ins == scs_pkg::INS_SET_DAC || ins == scs_pkg::INS_SET_EN ||
               ins == scs_pkg::INS_SET_MODE;
    endfunction

    function automatic logic dac_hi(input logic [4:0] a);
        return a >= scs_pkg::RA_DAC && a <= scs_pkg::RA_DAC_END && a[0];
    endfunction

    function automatic logic [7:0] ram_default(input logic [4:0] a);
        if (a <= scs_pkg::RA_RATES - 5'h01) begin
            return a[0] ? scs_pkg::DEF_EN_HI : scs_pkg::DEF_EN_LO;
        end else if (a >= scs_pkg::RA_DAC && a <= scs_pkg::RA_DAC_END) begin
            return a[0] ? scs_pkg::DEF_DAC_HI : scs_pkg::DEF_DAC_LO;
        end else if (a == scs_pkg::RA_PRESCALE) begin
            return scs_pkg::DEF_PRESCALE;
        end
        return scs_pkg::DEF_OTHER;
    endfunction

    // Pin synchronisers; first stage read only by the second
    logic       lock_m_q, lock_s_q;
    logic [7:0] slot_m_q, slot_s_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_m_q <= 1'b0;
            lock_s_q <= 1'b0;
            slot_m_q <= 8'h00;
            slot_s_q <= 8'h00;
        end else if (ce) begin
            lock_m_q <= clk_locked;
            lock_s_q <= lock_m_q;
            slot_m_q <= slot_addr;
            slot_s_q <= slot_m_q;
        end
    end

    // Memories and their port drives
    logic       ram_we, pkt_we;
    logic [4:0] ram_wa, ram_ra;
    logic [3:0] pkt_wa, pkt_ra;
    logic [7:0] ram_wd, pkt_wd, ram_rd, pkt_rd;

    scs_ram #(.DEPTH(32), .AW(5)) u_regs (
        .clk(clk), .ce(ce), .we(ram_we), .waddr(ram_wa), .wdata(ram_wd),
        .raddr(ram_ra), .rdata_q(ram_rd)
    );
    scs_ram #(.DEPTH(16), .AW(4)) u_pkt (
        .clk(clk), .ce(ce), .we(pkt_we), .waddr(pkt_wa), .wdata(pkt_wd),
        .raddr(pkt_ra), .rdata_q(pkt_rd)
    );

    // Link controller state
    scs_link_t                   lnk_q;
    logic [3:0]                  rx_cnt_q, tx_idx_q;
    logic [7:0]                  crc_q, dst_q, src_q, ins_q, tx_data_q, tx_crc_q;
    logic [scs_pkg::TIMER_W-1:0] tmr_q;
    logic                        cmd_go_q, err_go_q, tx_ph_q, tx_valid_q;
    // Main controller state
    scs_main_t                   mst_q;
    logic [4:0]                  idx_q;
    logic                        ph_q, cmd_pend_q, err_pend_q, cnt_pend_q;
    scs_pkg::scs_counts_t        cnt_hold_q;
    logic                        main_ready;

    wire rx_take  = lnk_q == L_RX && rx_valid &&
                    (rx_cnt_q != scs_pkg::POS_SOF || rx_data == scs_pkg::SOF_BYTE); // R7 R24
    wire rx_last  = rx_take && rx_cnt_q == scs_pkg::POS_CRC;
    wire dst_ok   = dst_q == slot_s_q && slot_s_q <= scs_pkg::MAX_SLOT; // R1 R2 R23
    wire crc_ok   = crc_q == rx_data; // R9
    wire tmr_hit  = tmr_q == scs_pkg::TIMER_W'(TIMEOUT_CYC - 1);
    wire [3:0] len = cmd_len(ins_q);
    wire       cmd_wr = is_write(ins_q);

    // Receiver: byte count, header capture, running checksum, time-out
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_cnt_q <= 4'h0;
            crc_q    <= scs_pkg::CRC_INIT;
            dst_q    <= 8'h00;
            src_q    <= 8'h00;
            ins_q    <= 8'h00;
            tmr_q    <= '0;
        end else if (ce) begin
            if (rx_take) begin
                rx_cnt_q <= rx_cnt_q + 4'h1; // R3
                tmr_q    <= '0;
                crc_q    <= (rx_cnt_q == scs_pkg::POS_SOF) ?
                            scs_pkg::crc8_byte(scs_pkg::CRC_INIT, rx_data) :
                            scs_pkg::crc8_byte(crc_q, rx_data); // R9 R24
                if (rx_cnt_q == scs_pkg::POS_DST) dst_q <= rx_data; // R8
                if (rx_cnt_q == scs_pkg::POS_SRC) src_q <= rx_data;
                if (rx_cnt_q == scs_pkg::POS_INS) ins_q <= rx_data;
            end else if (rx_cnt_q != scs_pkg::POS_SOF) begin
                if (tmr_hit) begin
                    rx_cnt_q <= scs_pkg::POS_SOF; // R4
                    tmr_q    <= '0;
                end else begin
                    tmr_q <= tmr_q + 1'b1;
                end
            end
        end
    end

    // Link sequence: receive, wait for main, transmit the answer
    always_ff @(posedge clk) begin
        if (rst) begin
            lnk_q    <= L_RX;
            cmd_go_q <= 1'b0;
            err_go_q <= 1'b0;
        end else if (ce) begin
            cmd_go_q <= 1'b0;
            err_go_q <= 1'b0;
            case (lnk_q)
                L_RX: begin
                    // Foreign packets are dropped before the checksum verdict
                    if (rx_last && dst_ok) begin // R23
                        if (!crc_ok) begin
                            err_go_q <= 1'b1; // R10
                        end else if (ins_q < scs_pkg::INS_LIMIT) begin
                            cmd_go_q <= 1'b1; // R19
                            lnk_q    <= L_WAIT;
                        end
                    end
                end
                L_WAIT: if (main_ready) lnk_q <= L_TX; // R19
                L_TX: begin
                    if (tx_valid_q && tx_ready && tx_idx_q == scs_pkg::POS_CRC) begin
                        lnk_q <= L_RX; // R19
                    end
                end
                default: lnk_q <= L_RX;
            endcase
        end
    end

    // Transmitter: fetch, present, handshake; checksum recomputed
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_idx_q   <= 4'h0;
            tx_ph_q    <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
            tx_crc_q   <= scs_pkg::CRC_INIT;
        end else if (ce) begin
            if (lnk_q != L_TX) begin
                tx_idx_q   <= 4'h0;
                tx_ph_q    <= 1'b0;
                tx_valid_q <= 1'b0;
                tx_crc_q   <= scs_pkg::CRC_INIT;
            end else if (tx_valid_q) begin
                if (tx_ready) begin
                    tx_valid_q <= 1'b0;
                    tx_idx_q   <= tx_idx_q + 4'h1;
                    // Swapped addresses change the sum, so it is rebuilt per sent byte
                    tx_crc_q   <= scs_pkg::crc8_byte(tx_crc_q, tx_data_q); // R9
                end
            end else if (!tx_ph_q) begin
                tx_ph_q <= 1'b1;
            end else begin
                tx_ph_q    <= 1'b0;
                tx_valid_q <= 1'b1; // R5
                tx_data_q  <= (tx_idx_q == scs_pkg::POS_CRC) ? tx_crc_q : pkt_rd;
            end
        end
    end

    // Packet buffer ports: receiver and transmitter never overlap main use
    always_comb begin
        pkt_we = 1'b0;
        pkt_wa = rx_cnt_q;
        pkt_wd = rx_data;
        pkt_ra = tx_idx_q;
        if (lnk_q == L_RX) begin
            pkt_we = rx_take;
        end else if (lnk_q == L_TX) begin
            if (tx_idx_q == scs_pkg::POS_DST) pkt_ra = scs_pkg::POS_SRC; // R6
            if (tx_idx_q == scs_pkg::POS_SRC) pkt_ra = scs_pkg::POS_DST; // R6
        end else if (mst_q == M_CMD) begin
            pkt_ra = scs_pkg::POS_PAY + idx_q[3:0];
            pkt_we = ph_q && !cmd_wr; // R13
            pkt_wa = scs_pkg::POS_PAY + idx_q[3:0];
            pkt_wd = ram_rd;
        end
    end

    // Pending events; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_pend_q <= 1'b0;
            err_pend_q <= 1'b0;
            cnt_pend_q <= 1'b0;
            cnt_hold_q <= '0;
        end else if (ce) begin
            // Cleared on the way back to running; a ping never visits the command state
            cmd_pend_q <= cmd_go_q || (cmd_pend_q && mst_q != M_DONE);
            err_pend_q <= err_go_q || (err_pend_q && mst_q != M_ERR);
            cnt_pend_q <= counts_valid || (cnt_pend_q && mst_q != M_STORE);
            if (counts_valid) cnt_hold_q <= counts;
        end
    end

    // Main controller sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            mst_q <= M_IDLE;
            idx_q <= 5'h00;
            ph_q  <= 1'b0;
        end else if (ce) begin
            case (mst_q)
                M_IDLE: if (lock_s_q) mst_q <= M_INIT; // R15
                M_INIT: begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == scs_pkg::RA_SPARE) mst_q <= M_RUN; // R16
                end
                M_RUN: begin
                    idx_q <= 5'h00;
                    ph_q  <= 1'b0;
                    if (cmd_pend_q) mst_q <= (len == 4'h0) ? M_DONE : M_CMD; // R14 R17
                    else if (err_pend_q) mst_q <= M_ERR; // R10
                    else if (cnt_pend_q) mst_q <= M_STORE; // R17
                end
                M_STORE: begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q[3:0] == scs_pkg::N_RATES) mst_q <= M_RUN;
                end
                M_ERR: begin
                    ph_q <= ~ph_q;
                    if (ph_q) mst_q <= M_RUN;
                end
                M_CMD, M_CONFIG: begin
                    ph_q <= ~ph_q;
                    if (ph_q) begin
                        idx_q <= idx_q + 5'h01;
                        if (idx_q[3:0] == len - 4'h1) begin
                            idx_q <= 5'h00;
                            mst_q <= (mst_q == M_CMD && cmd_wr) ? M_CONFIG : M_DONE;
                        end
                    end
                end
                M_DONE: mst_q <= M_RUN; // R17
                default: mst_q <= M_IDLE;
            endcase
        end
    end

    assign main_ready = mst_q == M_DONE;

    // Register RAM ports, driven only from the main controller
    always_comb begin
        ram_we = 1'b0;
        ram_wa = idx_q;
        ram_wd = ram_default(idx_q);
        ram_ra = ram_addr(ins_q, idx_q[3:0]);
        case (mst_q)
            M_INIT: ram_we = 1'b1; // R16 R20
            M_STORE: begin
                ram_we = 1'b1;
                ram_wa = ram_addr(scs_pkg::INS_RD_RATES, idx_q[3:0]);
                ram_wd = (idx_q[3:0] < scs_pkg::N_RATES) ?
                         cnt_hold_q.cnt[idx_q[3:1]][idx_q[0]*8 +: 8] : {3'h0, cnt_hold_q.ovf};
            end
            M_ERR: begin
                ram_ra = scs_pkg::RA_CRC_ERR;
                ram_we = ph_q;
                ram_wa = scs_pkg::RA_CRC_ERR;
                ram_wd = ram_rd + 8'h01; // R10
            end
            M_CMD: begin
                // Only set codes write, and their map holds no read-only byte
                ram_we = ph_q && cmd_wr; // R12 R21
                ram_wa = ram_addr(ins_q, idx_q[3:0]);
                ram_wd = dac_hi(ram_wa) ? {scs_pkg::DAC_HI_MASK, pkt_rd[3:0]} : pkt_rd; // R22
            end
            default: ;
        endcase
    end

    // Settings stream after a write command
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_valid <= 1'b0;
            cfg       <= '0;
        end else if (ce) begin
            cfg_valid <= mst_q == M_CONFIG && ph_q; // R12
            if (mst_q == M_CONFIG && ph_q) begin
                cfg.addr <= ram_ra;
                cfg.data <= ram_rd;
            end
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_data  = tx_data_q;
    assign rx_en    = lnk_q == L_RX;  // R18
    assign drive_en = lnk_q == L_TX;  // R5
    assign running  = mst_q == M_RUN;

    // Checks
    a_tx_only_reply: assert property (@(posedge clk) disable iff (rst) // R5
        tx_valid |-> drive_en && !rx_en) else $error("transmit outside reply");
    a_start_delim: assert property (@(posedge clk) disable iff (rst) // R7
        tx_valid && tx_idx_q == scs_pkg::POS_SOF |-> tx_data == scs_pkg::SOF_BYTE)
        else $error("reply does not open with delimiter");
    a_addr_swap: assert property (@(posedge clk) disable iff (rst) // R6
        tx_valid && tx_idx_q == scs_pkg::POS_DST |-> tx_data == src_q)
        else $error("reply destination is not the sender");
    a_bad_crc_silent: assert property (@(posedge clk) disable iff (rst) // R10
        err_go_q |-> lnk_q == L_RX) else $error("bad packet left receive state");
    a_err_counted: assert property (@(posedge clk) disable iff (rst) // R10
        ce && err_go_q && mst_q == M_RUN && !cmd_pend_q && !cnt_pend_q |=> ##1 mst_q == M_ERR)
        else $error("error count not started");
    a_cmd_addressed: assert property (@(posedge clk) disable iff (rst) // R23
        cmd_go_q |-> dst_q == slot_s_q && $past(crc_ok)) else $error("foreign or bad command");
    a_idle_unlocked: assert property (@(posedge clk) disable iff (rst) // R15
        mst_q == M_IDLE && !lock_s_q |=> mst_q == M_IDLE) else $error("left idle before lock");
    a_timeout_drop: assert property (@(posedge clk) disable iff (rst) // R4
        ce && tmr_hit && !rx_take && rx_cnt_q != scs_pkg::POS_SOF |=> rx_cnt_q == scs_pkg::POS_SOF)
        else $error("time-out did not drop packet");
    a_ro_untouched: assert property (@(posedge clk) disable iff (rst) // R21
        ram_we && mst_q == M_CMD |-> !(ram_wa >= scs_pkg::RA_RATES && ram_wa <= scs_pkg::RA_RATES_END)
        && ram_wa != scs_pkg::RA_OVF && ram_wa != scs_pkg::RA_CRC_ERR)
        else $error("master wrote read-only register");
    a_dac_nibble: assert property (@(posedge clk) disable iff (rst) // R22
        cfg_valid && dac_hi(cfg.addr) |-> cfg.data[7:4] == scs_pkg::DAC_HI_MASK)
        else $error("converter high nibble not zero");
    a_back_to_run: assert property (@(posedge clk) disable iff (rst) // R17
        ce && mst_q == M_DONE |=> mst_q == M_RUN ##1 lnk_q == L_TX || !ce)
        else $error("command did not return to running");

    c_ping_reply: cover property (@(posedge clk) disable iff (rst)
        cmd_go_q && ins_q == scs_pkg::INS_PING ##[1:60] tx_valid && tx_ready);
    c_bad_crc: cover property (@(posedge clk) disable iff (rst) err_go_q);
    c_config: cover property (@(posedge clk) disable iff (rst) cfg_valid && dac_hi(cfg.addr));
    c_store: cover property (@(posedge clk) disable iff (rst) mst_q == M_STORE);
endmodule

// [scs_pkg.sv]
// Shared constants, types and helpers of the slow-control packet slave
package scs_pkg;
    // Packet layout
    localparam logic [3:0] POS_SOF  = 4'h0;
    localparam logic [3:0] POS_DST  = 4'h1;
    localparam logic [3:0] POS_SRC  = 4'h2;
    localparam logic [3:0] POS_INS  = 4'h3;
    localparam logic [3:0] POS_PAY  = 4'h4;
    localparam logic [3:0] POS_CRC  = 4'hf;
    localparam logic [7:0] SOF_BYTE    = 8'h40;
    localparam logic [7:0] MASTER_ADDR = 8'hc0;
    localparam logic [7:0] MAX_SLOT    = 8'h27;

    // Checksum: x^8+x^2+x+1, zero start, msb first
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // Instruction codes
    localparam logic [7:0] INS_SET_DAC  = 8'h00;
    localparam logic [7:0] INS_RD_DAC   = 8'h01;
    localparam logic [7:0] INS_RD_RATES = 8'h02;
    localparam logic [7:0] INS_SET_EN   = 8'h03;
    localparam logic [7:0] INS_RD_EN    = 8'h04;
    localparam logic [7:0] INS_PING     = 8'h05;
    localparam logic [7:0] INS_SET_MODE = 8'h06;
    localparam logic [7:0] INS_RD_MODE  = 8'h07;
    localparam logic [7:0] INS_LIMIT    = 8'h08;

    // Register RAM map
    localparam logic [4:0] RA_ENABLE   = 5'h00;
    localparam logic [4:0] RA_RATES    = 5'h08;
    localparam logic [4:0] RA_RATES_END = 5'h11;
    localparam logic [4:0] RA_DAC      = 5'h12;
    localparam logic [4:0] RA_DAC_END  = 5'h1b;
    localparam logic [4:0] RA_PRESCALE = 5'h1c;
    localparam logic [4:0] RA_OVF      = 5'h1d;
    localparam logic [4:0] RA_CRC_ERR  = 5'h1e;
    localparam logic [4:0] RA_SPARE    = 5'h1f;

    // Bytes moved per instruction
    localparam logic [3:0] N_ENABLE   = 4'h8;
    localparam logic [3:0] N_RATES    = 4'ha;
    localparam logic [3:0] N_RATES_RD = 4'hb;
    localparam logic [3:0] N_DAC      = 4'ha;
    localparam logic [3:0] N_PRESCALE = 4'h1;
    localparam logic [3:0] N_CNTMODE  = 4'h2;

    // Register defaults written after clock lock
    localparam logic [7:0] DEF_EN_LO    = 8'hff;
    localparam logic [7:0] DEF_EN_HI    = 8'h01;
    localparam logic [7:0] DEF_DAC_LO   = 8'h00;
    localparam logic [7:0] DEF_DAC_HI   = 8'h00;
    localparam logic [7:0] DEF_PRESCALE = 8'h00;
    localparam logic [7:0] DEF_OTHER    = 8'h00;
    localparam logic [3:0] DAC_HI_MASK  = 4'h0;

    // Timing
    localparam int CLK_KHZ     = 125000;
    localparam int TIMEOUT_US  = 2000;
    localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_KHZ / 1000);
    localparam int TIMER_W     = 18;

    // Completed counts: five 16-bit counters and their overflow flags
    typedef struct packed {
        logic [4:0]       ovf;
        logic [4:0][15:0] cnt;
    } scs_counts_t;

    // One settings byte handed to the units that apply it
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } scs_cfg_t;

    // Checksum step over one byte
    function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction
endpackage

// [scs_ram.sv]
// Small simple dual-port byte memory with registered read data
`timescale 1ns/1ps
module scs_ram #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock and enable
    input  wire logic          clk,
    input  wire logic          ce,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic [7:0]         rdata_q
);
    logic [7:0] mem [DEPTH];

    // Contents need no reset; every byte is written before its value is used
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data from a register, one cycle after the address
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule

// [scs_master_model.sv]
// Trigger master stand-in: sends packets, accepts reply bytes
`timescale 1ns/1ps
module scs_master_model (
    // Reply from the slave
    input  wire logic        clk,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready,
    // Bytes to the slave
    output logic             rx_valid,
    output logic [7:0]       rx_data
);
    logic [15:0][7:0] reply;
    int               n_reply = 0;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end
    // Addressed packet, bytes back to back; n below 16 leaves it broken
    task automatic send(input logic [15:0][7:0] p, input int n);
        n_reply = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data  = p[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data; // Idle line shows no stale byte
    endtask
    // Slow line driver: ready rises half a cycle after valid and drops after each byte
    always @(negedge clk) tx_ready = tx_valid && !tx_ready;
    always @(posedge clk) if (tx_valid && tx_ready) begin
        reply[n_reply] <= tx_data;
        n_reply <= n_reply + 1;
    end
endmodule

// [scs_slave_test.sv]
// Self-checking bench of the slow-control packet slave
`timescale 1ns/1ps
module scs_slave_test;
    logic clk = 1'b0, rst = 1'b1, clk_locked = 1'b0;
    logic tx_valid, tx_ready, rx_valid, rx_en, drive_en, cfg_valid, running;
    logic [7:0] tx_data, rx_data;
    scs_pkg::scs_cfg_t cfg;
    logic counts_valid = 1'b0;
    scs_pkg::scs_counts_t counts = '0;
    logic [15:0][7:0] pk, ex;
    int n_fail = 0, total_checks = 0, n_cfg = 0, cyc = 0;
    initial forever #4 clk = ~clk;
    scs_slave #(.TIMEOUT_CYC(200)) u_scs_slave (.clk(clk), .rst(rst), .ce(1'b1),
        .clk_locked(clk_locked), .slot_addr(8'h27), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_en(rx_en),
        .drive_en(drive_en), .counts_valid(counts_valid), .counts(counts), .cfg_valid(cfg_valid),
        .cfg(cfg), .running(running));
    scs_master_model u_scs_master_model (.clk(clk), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data));
    // Settings bytes and hang guard
    always @(posedge clk) begin
        n_cfg += int'(cfg_valid === 1'b1);
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bit-serial reference, kept apart from the design's byte step
    function automatic logic [7:0] crc_of(input logic [15:0][7:0] p);
        logic [7:0] c = 8'h00;
        for (int i = 0; i < 15; i++)
            for (int b = 7; b >= 0; b--)
                c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i][b]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // One packet out, reply judged; payload bytes 4-13 expected lo/hi alternating, byte 14 the fill
    task automatic xfer(input logic [7:0] dst, ins, fill, input logic bad, input int n,
                        input logic [7:0] lo, hi);
        pk = {16{fill}};
        pk[0] = 8'h40;
        pk[1] = dst;
        pk[2] = 8'hc0;
        pk[3] = ins;
        pk[15] = crc_of(pk) ^ {7'h0, bad};
        ex = pk;
        ex[1] = 8'hc0;
        ex[2] = dst;
        for (int i = 4; i < 14; i++) ex[i] = i[0] ? hi : lo;
        ex[15] = crc_of(ex);
        u_scs_master_model.send(pk, 16);
        for (int i = 0; i < 300 && !(u_scs_master_model.n_reply == 16 && rx_en); i++)
            @(negedge clk);
        check("reply bytes", 8'(u_scs_master_model.n_reply), 8'(n));
        for (int i = 0; i < 16 && n == 16; i++)
            check("reply byte", u_scs_master_model.reply[i], ex[i]);
        check("rx_en", {7'h0, rx_en}, 8'h01);
        check("drive_en", {7'h0, drive_en}, 8'h00);
    endtask
    task automatic t_ping_foreign();
        xfer(8'h27, 8'h05, 8'h33, 1'b0, 16, 8'h33, 8'h33);
        xfer(8'h26, 8'h05, 8'h33, 1'b0, 0, 8'h33, 8'h33);
        xfer(8'h27, 8'h08, 8'h33, 1'b0, 0, 8'h33, 8'h33);
    endtask
    task automatic t_bad_crc();
        xfer(8'h27, 8'h05, 8'h5a, 1'b1, 0, 8'h5a, 8'h5a);
        xfer(8'h27, 8'h05, 8'h5a, 1'b0, 16, 8'h5a, 8'h5a);
    endtask
    task automatic t_settings();
        n_cfg = 0;
        xfer(8'h27, 8'h00, 8'hff, 1'b0, 16, 8'hff, 8'hff);
        check("dac bytes", 8'(n_cfg), 8'h0a);
        xfer(8'h27, 8'h01, 8'hff, 1'b0, 16, 8'hff, 8'h0f);
        n_cfg = 0;
        xfer(8'h27, 8'h03, 8'h01, 1'b0, 16, 8'h01, 8'h01);
        check("enable bytes", 8'(n_cfg), 8'h08);
        xfer(8'h27, 8'h04, 8'h01, 1'b0, 16, 8'h01, 8'h01);
    endtask
    // Broken packet must not swallow the next one
    task automatic t_timeout();
        u_scs_master_model.send(pk, 7);
        repeat (210) @(negedge clk);
        xfer(8'h27, 8'h05, 8'h11, 1'b0, 16, 8'h11, 8'h11);
    endtask
    // Counting period stored, then read back; prescale written and read
    task automatic t_rates();
        counts = {5'h15, {5{16'h1234}}};
        counts_valid = 1'b1;
        @(negedge clk);
        counts_valid = 1'b0;
        repeat (20) @(negedge clk);
        xfer(8'h27, 8'h02, 8'h15, 1'b0, 16, 8'h34, 8'h12);
        n_cfg = 0;
        xfer(8'h27, 8'h06, 8'h15, 1'b0, 16, 8'h15, 8'h15);
        check("prescale bytes", 8'(n_cfg), 8'h01);
        xfer(8'h27, 8'h07, 8'h15, 1'b0, 16, 8'h15, 8'h15);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        check("running unlocked", {7'h0, running}, 8'h00);
        clk_locked = 1'b1;
        repeat (40) @(negedge clk);
        check("running", {7'h0, running}, 8'h01);
        t_ping_foreign();
        t_bad_crc();
        t_settings();
        t_timeout();
        t_rates();
        print_verdict();
    end
endmodule
